//--- verilog/mem_front_consts.svh
`ifndef MEM_FRONT_CONSTS_SVH
`define MEM_FRONT_CONSTS_SVH
// register word indices on the register port (address bits 11:2)
`define ITCR_IDX 10'h3A0
`define ITIP_IDX 10'h3A2
// test input register field positions
`define ITIP_BACKOFF 6
`define ITIP_TICGNT 5
`define ITIP_GNT 4
`define ITIP_MUX 3
`define ITIP_RATIO_HI 2
`define ITIP_RATIO_LO 1
`define ITIP_BIGEND 0
`define ITIP_USED_W 7
`define ITIP_RESET 7'h00
`define ITCR_RESET 1'b0
// memory window: 4 KB per bank, one word per entry
`define MEM_AW 10
`define MEM_BANKS 8
`endif

//--- verilog/mem_front_pkg.sv
package mem_front_pkg;
  typedef enum logic [1:0] {TR_IDLE, TR_BUSY, TR_NSEQ, TR_SEQ} htrans_e;
  typedef enum logic [2:0] {
    BU_SINGLE, BU_INCR, BU_WRAP4, BU_INCR4, BU_WRAP8, BU_INCR8, BU_WRAP16, BU_INCR16
  } hburst_e;
  typedef enum logic [1:0] {RS_OKAY, RS_ERROR, RS_RETRY, RS_SPLIT} hresp_e;
  typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_ERR1, PH_ERR2} phase_e;
  // sampled address phase of a transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] size;
    logic [1:0] lsb;
    logic [9:0] word;
    logic [2:0] bank;
  } aphase_s;
  // live integration inputs
  typedef struct packed {
    logic backoff;
    logic tic_grant;
    logic grant;
    logic mux_sel;
    logic [1:0] clk_ratio;
    logic big_endian;
  } itin_s;
endpackage : mem_front_pkg

//--- verilog/bank_ram.sv
`timescale 1ns/1ps
`default_nettype none
`include "mem_front_consts.svh"
// byte-lane word store standing for the external banks; read data registered
module bank_ram (
  input wire logic clock,
  input wire logic [12:0] addr,
  input wire logic [3:0] be,
  input wire logic we,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:(1 << 13) - 1];
  genvar i;
  // one lane per byte enable
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lane
      always_ff @(posedge clock) begin
        if (we && be[i]) mem[addr][8*i +: 8] <= wdata[8*i +: 8];
      end
    end
  endgenerate
  always_ff @(posedge clock) begin
    rdata <= mem[addr];
  end
endmodule : bank_ram
`default_nettype wire

//--- verilog/mem_front.sv
// Operation
// RL1: test input bits drive, read live signals
// RL2: bits 31:7 read zero, write ignored
// RL3: test values used only when enabled
// RL4: separate register and memory slave ports
// RL5: register port decodes address bits 11:2
// RL6: register access only when selected
// RL7: eight bank selects route memory transfers
// RL8: fixed incrementing and wrapping bursts accepted
// RL9: byte, halfword and word sizes handled
// RL10: idle, busy, nonseq, seq all accepted
// RL11: sample address only when ready in high
// RL12: ready out low while access pending
// RL13: only okay or error responses
// RL14: write high means write into device
// RL15: everything on rising bus clock edge
// RL16: active-low reset clears bus state
// RL17: error is two-cycle ready low then high
// RL18: idle, busy, unselected get zero-wait okay
`timescale 1ns/1ps
`default_nettype none
`include "mem_front_consts.svh"
module mem_front (
  input wire logic clock,
  input wire logic rstn,
  // register port
  input wire logic cfg_port_hsel,
  input wire logic [11:2] cfg_port_haddr,
  input wire logic [1:0] cfg_port_htrans,
  input wire logic [2:0] cfg_port_hsize,
  input wire logic cfg_port_hwrite,
  input wire logic [31:0] cfg_port_hwdata,
  input wire logic cfg_port_hready_in,
  output logic [31:0] cfg_port_hrdata,
  output logic cfg_port_hready_out,
  output logic [1:0] cfg_port_hresp,
  // memory port
  input wire logic [7:0] mem_port_bank_hsel,
  input wire logic [11:0] mem_port_haddr,
  input wire logic [1:0] mem_port_htrans,
  input wire logic [2:0] mem_port_hburst,
  input wire logic [2:0] mem_port_hsize,
  input wire logic mem_port_hwrite,
  input wire logic [31:0] mem_port_hwdata,
  input wire logic mem_port_hready_in,
  output logic [31:0] mem_port_hrdata,
  output logic mem_port_hready_out,
  output logic [1:0] mem_port_hresp,
  // real integration input pins and the values the core uses
  input wire logic ext_bus_backoff_in,
  input wire logic test_ctrl_ext_bus_grant_in,
  input wire logic ext_bus_grant_in,
  input wire logic ext_bus_mux_select,
  input wire logic [1:0] memory_clock_ratio,
  input wire logic big_endian_select,
  output mem_front_pkg::itin_s core_inputs,
  output logic test_mode
);
  // pin synchronisers: first stage read only by the second
  mem_front_pkg::itin_s pin_meta_r, pin_sync_r;
  mem_front_pkg::itin_s itip_r;
  logic itcr_r;
  always_ff @(posedge clock or negedge rstn) begin // RL15 RL16
    if (!rstn) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {ext_bus_backoff_in, test_ctrl_ext_bus_grant_in, ext_bus_grant_in,
                     ext_bus_mux_select, memory_clock_ratio, big_endian_select};
      pin_sync_r <= pin_meta_r;
    end
  end

  // test register overrides the pins only in test mode
  wire mem_front_pkg::itin_s live_in = itcr_r ? itip_r : pin_sync_r; // RL3

  // ---------------- register port ----------------
  // address phase: only taken with hready_in high and a real transfer
  wire cfg_xfer = cfg_port_hready_in && cfg_port_hsel && cfg_port_htrans[1]; // RL6 RL10 RL11 RL18
  wire cfg_hit_itcr = (cfg_port_haddr == `ITCR_IDX); // RL5
  wire cfg_hit_itip = (cfg_port_haddr == `ITIP_IDX); // RL5
  wire cfg_hit = cfg_hit_itcr || cfg_hit_itip;
  logic cfg_wr_r, cfg_itcr_r, cfg_itip_r;
  mem_front_pkg::phase_e cfg_ph_r;

  // data phase pointer; write data arrives one cycle after the address
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_wr_r <= 1'b0;
      cfg_itcr_r <= 1'b0;
      cfg_itip_r <= 1'b0;
    end else if (cfg_port_hready_in) begin // RL11
      cfg_wr_r <= cfg_xfer && cfg_hit && cfg_port_hwrite; // RL14
      cfg_itcr_r <= cfg_hit_itcr;
      cfg_itip_r <= cfg_hit_itip;
    end else begin
      cfg_wr_r <= 1'b0;
    end
  end

  // registers; only the used low bits store, upper bits are dropped
  always_ff @(posedge clock or negedge rstn) begin // RL16
    if (!rstn) begin
      itcr_r <= `ITCR_RESET;
      itip_r <= `ITIP_RESET;
    end else if (cfg_wr_r) begin
      if (cfg_itcr_r) itcr_r <= cfg_port_hwdata[0];
      if (cfg_itip_r) itip_r <= cfg_port_hwdata[`ITIP_USED_W-1:0]; // RL1 RL2
    end
  end

  // read data is registered at address phase so it stands in the data phase
  wire [31:0] cfg_rd_nxt = cfg_hit_itip ? {25'h0000000, live_in} : // RL1 RL2
                           cfg_hit_itcr ? {31'h00000000, itcr_r} : 32'h00000000;
  // unmapped offsets answer with the two-cycle error
  wire cfg_err = cfg_xfer && !cfg_hit;
  mem_front_pkg::phase_e cfg_ph_nxt;
  always_comb begin
    cfg_ph_nxt = mem_front_pkg::PH_IDLE;
    case (cfg_ph_r)
      mem_front_pkg::PH_ERR1: cfg_ph_nxt = mem_front_pkg::PH_ERR2; // RL17
      default: cfg_ph_nxt = cfg_err ? mem_front_pkg::PH_ERR1 : mem_front_pkg::PH_IDLE;
    endcase
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_ph_r <= mem_front_pkg::PH_IDLE;
      cfg_port_hrdata <= 32'h00000000;
    end else begin
      cfg_ph_r <= cfg_ph_nxt;
      if (cfg_xfer && !cfg_port_hwrite) cfg_port_hrdata <= cfg_rd_nxt;
    end
  end
  // outputs straight from flops: ready low only in the first error cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_port_hready_out <= 1'b1;
      cfg_port_hresp <= mem_front_pkg::RS_OKAY;
    end else begin
      cfg_port_hready_out <= (cfg_ph_nxt != mem_front_pkg::PH_ERR1); // RL12 RL17 RL18
      cfg_port_hresp <= (cfg_ph_nxt == mem_front_pkg::PH_IDLE) ?
                        mem_front_pkg::RS_OKAY : mem_front_pkg::RS_ERROR; // RL13
    end
  end

  // ---------------- memory port ----------------
  // bank number from the one-hot selects, lowest wins if several
  logic [2:0] bank_num;
  always_comb begin
    bank_num = 3'h0;
    for (int b = `MEM_BANKS - 1; b >= 0; b--) begin
      if (mem_port_bank_hsel[b]) bank_num = 3'(b); // RL7
    end
  end
  wire mem_sel = |mem_port_bank_hsel; // RL7
  wire mem_xfer = mem_port_hready_in && mem_sel && mem_port_htrans[1]; // RL10 RL11 RL18
  // sizes above a word are not supported and get the error
  wire mem_size_ok = (mem_port_hsize <= 3'h2); // RL9
  // burst type is accepted as is; the master supplies each beat address so
  // incrementing and wrapping orders need no local generator
  wire mem_burst_ok = (mem_port_hburst <= mem_front_pkg::BU_INCR16); // RL8
  wire mem_err = mem_xfer && !(mem_size_ok && mem_burst_ok);
  mem_front_pkg::aphase_s mem_ap_r;
  mem_front_pkg::phase_e mem_ph_r, mem_ph_nxt;

  // capture address phase of an accepted memory transfer
  always_ff @(posedge clock or negedge rstn) begin // RL15 RL16
    if (!rstn) begin
      mem_ap_r <= '0;
    end else if (mem_port_hready_in) begin // RL11
      mem_ap_r.valid <= mem_xfer && !mem_err;
      mem_ap_r.write <= mem_port_hwrite; // RL14
      mem_ap_r.size <= mem_port_hsize;
      mem_ap_r.lsb <= mem_port_haddr[1:0];
      mem_ap_r.word <= mem_port_haddr[11:2];
      mem_ap_r.bank <= bank_num; // RL7
    end else begin
      mem_ap_r.valid <= 1'b0;
    end
  end

  // byte enables for the sampled size and offset
  logic [3:0] mem_be;
  always_comb begin
    case (mem_ap_r.size[1:0]) // RL9
      2'h0: mem_be = 4'h1 << mem_ap_r.lsb;
      2'h1: mem_be = mem_ap_r.lsb[1] ? 4'hC : 4'h3;
      default: mem_be = 4'hF;
    endcase
  end

  // reads take one wait state for the registered store read
  wire mem_rd_start = mem_xfer && !mem_err && !mem_port_hwrite;
  wire mem_wr_do = mem_ap_r.valid && mem_ap_r.write;
  // a read behind a write loses the store port to the write; it rereads a cycle later
  logic mem_rd_late_r;
  wire [12:0] ram_addr = mem_wr_do ? {mem_ap_r.bank, mem_ap_r.word} :
                         mem_rd_late_r ? {mem_ap_r.bank, mem_ap_r.word} :
                                         {bank_num, mem_port_haddr[11:2]};
  wire [31:0] ram_rdata;
  bank_ram u_ram (
    .clock(clock),
    .addr(ram_addr),
    .be(mem_be),
    .we(mem_wr_do),
    .wdata(mem_port_hwdata),
    .rdata(ram_rdata)
  );

  // memory phase sequencer
  always_comb begin
    mem_ph_nxt = mem_front_pkg::PH_IDLE;
    case (mem_ph_r)
      mem_front_pkg::PH_ERR1: mem_ph_nxt = mem_front_pkg::PH_ERR2; // RL17
      mem_front_pkg::PH_WAIT: mem_ph_nxt = mem_rd_late_r ? mem_front_pkg::PH_WAIT :
                                                           mem_front_pkg::PH_IDLE; // RL12
      default: begin
        if (mem_err) mem_ph_nxt = mem_front_pkg::PH_ERR1;
        else if (mem_rd_start) mem_ph_nxt = mem_front_pkg::PH_WAIT; // RL12
        else mem_ph_nxt = mem_front_pkg::PH_IDLE;
      end
    endcase
  end
  // a write address phase during a pending read wait is impossible: ready is low
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_ph_r <= mem_front_pkg::PH_IDLE;
      mem_rd_late_r <= 1'b0;
      mem_port_hready_out <= 1'b1;
      mem_port_hresp <= mem_front_pkg::RS_OKAY;
      mem_port_hrdata <= 32'h00000000;
    end else begin
      mem_ph_r <= mem_ph_nxt;
      mem_rd_late_r <= (mem_ph_r == mem_front_pkg::PH_IDLE || mem_ph_r == mem_front_pkg::PH_ERR2)
                       && mem_rd_start && mem_wr_do;
      mem_port_hready_out <= (mem_ph_nxt == mem_front_pkg::PH_IDLE) ||
                             (mem_ph_nxt == mem_front_pkg::PH_ERR2); // RL12 RL17
      mem_port_hresp <= (mem_ph_nxt == mem_front_pkg::PH_ERR1 ||
                         mem_ph_nxt == mem_front_pkg::PH_ERR2) ?
                        mem_front_pkg::RS_ERROR : mem_front_pkg::RS_OKAY; // RL13
      if (mem_ph_r == mem_front_pkg::PH_WAIT && !mem_rd_late_r) mem_port_hrdata <= ram_rdata;
    end
  end

  // test-muxed inputs delivered to the memory-side core
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      core_inputs <= '0;
      test_mode <= 1'b0;
    end else begin
      core_inputs <= live_in; // RL3
      test_mode <= itcr_r;
    end
  end
endmodule : mem_front
`default_nettype wire

//--- sim/ahb_master.sv
`timescale 1ns/1ps
`default_nettype none
// bus master for one port: one transfer at a time, request held until ready is seen high
module ahb_master #(parameter int SW = 1, parameter int AW = 10) (
  input wire logic clock,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] hresp,
  output logic [SW-1:0] hsel,
  output logic [AW-1:0] haddr,
  output logic [1:0] htrans,
  output logic [2:0] hburst,
  output logic [2:0] hsize,
  output logic hwrite,
  output logic [31:0] hwdata
);
  logic hung = 1'b0;
  initial {hsel, haddr, htrans, hburst, hsize, hwrite, hwdata} = '0;
  // ready is read at the rising edge, the same edge on which the slave acts
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (hready !== 1'b1) hung = 1'b1;
  endtask : wait_ready
  // nx is the type shown in the data phase: busy keeps a burst open
  task automatic xfer(input logic [SW-1:0] s, input logic [AW-1:0] a, input logic w,
      input logic [2:0] sz, b, input logic [1:0] tr, nx, input logic [31:0] wd,
      output logic [31:0] rd, output logic [1:0] rs);
    @(posedge clock);
    hsel <= s;
    haddr <= a;
    htrans <= tr;
    hburst <= b;
    hsize <= sz;
    hwrite <= w;
    hwdata <= ~hwdata;
    wait_ready();
    haddr <= ~a; // released lines must not keep the old value
    hwrite <= ~w;
    htrans <= nx;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    rs = hresp;
  endtask : xfer
endmodule : ahb_master
`default_nettype wire

//--- sim/mem_front_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "mem_front_consts.svh"
module mem_front_sva (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cfg_port_hsel,
  input wire logic [11:2] cfg_port_haddr,
  input wire logic [1:0] cfg_port_htrans,
  input wire logic cfg_port_hwrite,
  input wire logic [31:0] cfg_port_hwdata,
  input wire logic cfg_port_hready_in,
  input wire logic cfg_port_hready_out,
  input wire logic [1:0] cfg_port_hresp,
  input wire logic [7:0] mem_port_bank_hsel,
  input wire logic [1:0] mem_port_htrans,
  input wire logic [2:0] mem_port_hsize,
  input wire logic mem_port_hwrite,
  input wire logic mem_port_hready_in,
  input wire logic mem_port_hready_out,
  input wire logic [1:0] mem_port_hresp,
  input wire logic test_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic cfg_take;
  logic mem_take;
  // a transfer is taken only when selected, active and the bus is ready
  assign cfg_take = cfg_port_hready_in && cfg_port_hsel && cfg_port_htrans[1];
  assign mem_take = mem_port_hready_in && (|mem_port_bank_hsel) && mem_port_htrans[1];
  // error answer spans two cycles so the master can cancel its next request
  sequence err_s(r, p);
    !r && p == 2'h1 ##1 r && p == 2'h1;
  endsequence
  sequence rd_s(r, p);
    !r ##1 r && p == 2'h0;
  endsequence
  sequence rd_late_s(r, p);
    !r ##1 !r ##1 r && p == 2'h0;
  endsequence
  // a write is in its data phase: the store is busy for one cycle
  logic mem_wr_dp_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_wr_dp_r <= 1'b0;
    end else if (mem_port_hready_in) begin
      mem_wr_dp_r <= mem_take && mem_port_hwrite && mem_port_hsize < 3'h3;
    end else begin
      mem_wr_dp_r <= 1'b0;
    end
  end
  cfg_err_a: assert property (!cfg_port_hready_out |-> err_s(cfg_port_hready_out, cfg_port_hresp))
    else $error("register port wait without a two-cycle error");
  mem_err_a: assert property (!mem_port_hready_out && mem_port_hresp == 2'h1
    |-> err_s(mem_port_hready_out, mem_port_hresp)) else $error("memory error not two cycles");
  resp_legal_a: assert property (!cfg_port_hresp[1] && !mem_port_hresp[1])
    else $error("retry or split response seen");
  mem_rd_a: assert property (mem_take && !mem_port_hwrite && mem_port_hsize < 3'h3
    && !mem_wr_dp_r |=> rd_s(mem_port_hready_out, mem_port_hresp))
    else $error("memory read timing wrong");
  rd_late_a: assert property (mem_take && !mem_port_hwrite && mem_port_hsize < 3'h3
    && mem_wr_dp_r |=> rd_late_s(mem_port_hready_out, mem_port_hresp))
    else $error("memory read behind write timing wrong");
  mem_wr_a: assert property (mem_take && mem_port_hwrite && mem_port_hsize < 3'h3
    |=> mem_port_hready_out && mem_port_hresp == 2'h0) else $error("memory write not zero wait");
  mem_size_a: assert property (mem_take && mem_port_hsize > 3'h2
    |=> err_s(mem_port_hready_out, mem_port_hresp)) else $error("oversize transfer not refused");
  cfg_idle_a: assert property (cfg_port_hready_in && !cfg_take
    |=> cfg_port_hready_out && cfg_port_hresp == 2'h0) else $error("register idle not okay");
  mem_idle_a: assert property (mem_port_hready_in && !mem_take
    |=> mem_port_hready_out && mem_port_hresp == 2'h0) else $error("memory idle not okay");
  mode_wr_a: assert property (cfg_take && cfg_port_hwrite && cfg_port_haddr == `ITCR_IDX
    |=> ##2 test_mode == $past(cfg_port_hwdata[0], 2)) else $error("test mode not written");
endmodule : mem_front_sva
bind mem_front mem_front_sva mem_front_sva_inst (.clock, .rstn, .cfg_port_hsel, .cfg_port_haddr,
  .cfg_port_htrans, .cfg_port_hwrite, .cfg_port_hwdata, .cfg_port_hready_in, .cfg_port_hready_out,
  .cfg_port_hresp, .mem_port_bank_hsel, .mem_port_htrans, .mem_port_hsize, .mem_port_hwrite,
  .mem_port_hready_in, .mem_port_hready_out, .mem_port_hresp, .test_mode);
`default_nettype wire

//--- sim/tb_static_mem_ctrl_ahb_slave_ports.sv
`timescale 1ns/1ps
`default_nettype none
`include "mem_front_consts.svh"
module tb_static_mem_ctrl_ahb_slave_ports;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic cfg_port_hsel, cfg_port_hwrite, cfg_port_hready_in, cfg_port_hready_out;
  logic mem_port_hwrite, mem_port_hready_in, mem_port_hready_out, test_mode;
  logic [9:0] cfg_port_haddr;
  logic [11:0] mem_port_haddr;
  logic [7:0] mem_port_bank_hsel;
  logic [1:0] cfg_port_htrans, cfg_port_hresp, mem_port_htrans, mem_port_hresp, rs;
  logic [2:0] cfg_port_hsize, mem_port_hburst, mem_port_hsize;
  logic [31:0] cfg_port_hwdata, cfg_port_hrdata, mem_port_hwdata, mem_port_hrdata, rd;
  logic ext_bus_backoff_in, test_ctrl_ext_bus_grant_in, ext_bus_grant_in, ext_bus_mux_select;
  logic big_endian_select;
  logic [1:0] memory_clock_ratio;
  mem_front_pkg::itin_s core_inputs;
  int n_fail = 0;
  int n_tests = 0;
  // the interconnect hands each slave its own ready back
  assign cfg_port_hready_in = cfg_port_hready_out;
  assign mem_port_hready_in = mem_port_hready_out;
  always #25 clock = ~clock;
  mem_front mem_front_inst (.clock, .rstn, .cfg_port_hsel, .cfg_port_haddr, .cfg_port_htrans,
    .cfg_port_hsize, .cfg_port_hwrite, .cfg_port_hwdata, .cfg_port_hready_in, .cfg_port_hrdata,
    .cfg_port_hready_out, .cfg_port_hresp, .mem_port_bank_hsel, .mem_port_haddr, .mem_port_htrans,
    .mem_port_hburst, .mem_port_hsize, .mem_port_hwrite, .mem_port_hwdata, .mem_port_hready_in,
    .mem_port_hrdata, .mem_port_hready_out, .mem_port_hresp, .ext_bus_backoff_in,
    .test_ctrl_ext_bus_grant_in, .ext_bus_grant_in, .ext_bus_mux_select, .memory_clock_ratio,
    .big_endian_select, .core_inputs, .test_mode);
  ahb_master #(.SW(1), .AW(10)) cfg_master_inst (.clock, .hready(cfg_port_hready_out),
    .hrdata(cfg_port_hrdata), .hresp(cfg_port_hresp), .hsel(cfg_port_hsel),
    .haddr(cfg_port_haddr), .htrans(cfg_port_htrans), .hburst(), .hsize(cfg_port_hsize),
    .hwrite(cfg_port_hwrite), .hwdata(cfg_port_hwdata));
  ahb_master #(.SW(8), .AW(12)) mem_master_inst (.clock, .hready(mem_port_hready_out),
    .hrdata(mem_port_hrdata), .hresp(mem_port_hresp), .hsel(mem_port_bank_hsel),
    .haddr(mem_port_haddr), .htrans(mem_port_htrans), .hburst(mem_port_hburst),
    .hsize(mem_port_hsize), .hwrite(mem_port_hwrite), .hwdata(mem_port_hwdata));
  task results();
    if (cfg_master_inst.hung || mem_master_inst.hung) n_fail++;
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // a hung master counts as a mismatch and ends the run
  task chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      n_fail++;
    end
    if (cfg_master_inst.hung || mem_master_inst.hung) begin
      n_fail++;
      results();
    end
  endtask : chk
  task pins(input logic [6:0] v);
    @(posedge clock);
    {ext_bus_backoff_in, test_ctrl_ext_bus_grant_in, ext_bus_grant_in, ext_bus_mux_select,
      memory_clock_ratio, big_endian_select} <= v;
  endtask : pins
  task rx(input logic s, input logic [9:0] a, input logic w, input logic [1:0] t, input logic [31:0] d);
    cfg_master_inst.xfer(s, a, w, 3'h2, 3'h0, t, 2'h0, d, rd, rs);
  endtask : rx
  task mx(input int k, input logic [11:0] a, input logic w, input logic [2:0] z, b,
      input logic [1:0] t, n, input logic [31:0] d);
    mem_master_inst.xfer(8'h01 << k, a, w, z, b, t, n, d, rd, rs);
  endtask : mx
  task t_reg();
    rx(1'b1, `ITIP_IDX, 1'b1, 2'h2, 32'h0000_004A);
    rx(1'b1, `ITCR_IDX, 1'b1, 2'h2, 32'h0000_0001);
    // register lands at the data edge, the copies one edge later
    repeat (2) @(posedge clock);
    chk({31'h0, test_mode}, 32'h1);
    chk({25'h0, core_inputs}, 32'h4A);
    // unselected, idle and busy leave the register untouched
    for (int t = 0; t < 3; t++) begin
      rx(t != 0, `ITIP_IDX, 1'b1, (t == 0) ? 2'h2 : 2'(t - 1), 32'h0000_0035);
      chk({30'h0, rs}, 32'h0);
    end
    rx(1'b1, `ITIP_IDX, 1'b0, 2'h2, 32'h0);
    chk(rd, 32'h0000_004A);
    rx(1'b1, 10'h155, 1'b0, 2'h2, 32'h0);
    chk({30'h0, rs}, 32'h1);
    rx(1'b1, `ITCR_IDX, 1'b1, 2'h2, 32'h0);
    repeat (4) @(posedge clock);
    chk({25'h0, core_inputs}, 32'h35);
    rx(1'b1, `ITIP_IDX, 1'b0, 2'h3, 32'h0);
    chk(rd, 32'h0000_0035);
  endtask : t_reg
  task t_mem();
    for (int k = 0; k < 8; k++) mx(k, 12'h040, 1'b1, 3'h2, 3'h0, 2'h2, 2'h0, 32'hC0DE_0000 + k);
    for (int k = 0; k < 8; k++) begin
      mx(k, 12'h040, 1'b0, 3'h2, 3'h0, 2'h2, 2'h0, 32'h0);
      chk(rd, 32'hC0DE_0000 + k);
    end
    for (int i = 0; i < 4; i++) mx(0, 12'h100 + i, 1'b1, 3'h0, 3'h0, 2'h2, 2'h0, {4{8'hA0 + 8'(i)}});
    mx(0, 12'h102, 1'b1, 3'h1, 3'h0, 2'h2, 2'h0, 32'h5A5A_5A5A);
    mx(0, 12'h100, 1'b0, 3'h2, 3'h0, 2'h2, 2'h0, 32'h0);
    chk(rd, 32'h5A5A_A1A0);
    mx(0, 12'h100, 1'b0, 3'h3, 3'h0, 2'h2, 2'h0, 32'h0);
    chk({30'h0, rs}, 32'h1);
  endtask : t_mem
  // each fixed-length burst code (WRAP4 to INCR16) on its own bank; wrapping starts mid-block so the address folds
  task t_burst();
    int n;
    logic [11:0] m;
    for (int b = 2; b < 8; b++) begin
      n = 4 << ((b - 2) / 2);
      m = 12'(n * 4 - 1);
      for (int i = 0; i < n; i++) mx(b, b[0] ? 12'h208 + 12'(4 * i) : (12'h208 & ~m) |
        ((12'h208 + 12'(4 * i)) & m), 1'b1, 3'h2, 3'(b), (i == 0) ? 2'h2 : 2'h3,
        (i == n - 1) ? 2'h0 : 2'h1, 32'(b * 256 + i));
      for (int i = 0; i < n; i++) begin
        mx(b, b[0] ? 12'h208 + 12'(4 * i) : (12'h208 & ~m) | ((12'h208 + 12'(4 * i)) & m),
          1'b0, 3'h2, 3'h0, 2'h2, 2'h0, 32'h0);
        chk(rd, 32'(b * 256 + i));
      end
    end
  endtask : t_burst
  initial begin
    {ext_bus_backoff_in, test_ctrl_ext_bus_grant_in, ext_bus_grant_in, ext_bus_mux_select,
      memory_clock_ratio, big_endian_select} = 7'h00;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    pins(7'h35);
    repeat (4) @(posedge clock);
    chk({25'h0, core_inputs}, 32'h35);
    chk({31'h0, test_mode}, 32'h0);
    t_reg();
    t_mem();
    t_burst();
    results();
  end
endmodule : tb_static_mem_ctrl_ahb_slave_ports
`default_nettype wire
